// >>> bpr_pkg.sv
package bpr_pkg;

  // Routing select values for the shared pin group.
  localparam logic ROUTE_DEFAULT = 1'b0;
  localparam logic ROUTE_AUDIO   = 1'b1;

  // Reset values of the software settings.
  localparam logic RST_ROUTE_SEL  = 1'b0;
  localparam logic RST_CLK_MASTER = 1'b0;
  localparam logic RST_SYN_MASTER = 1'b0;

  // Sleep clock: nominal 32.768 kHz, i.e. about 3052 system cycles per period at 100 MHz.
  localparam int SYS_CLK_HZ        = 100_000_000;
  localparam int SLEEP_CLK_MHZ_X1K = 32768;
  // Longest period without a sleep clock edge before it is declared absent (four nominal periods).
  localparam int SLEEP_TIMEOUT_CYC = (SYS_CLK_HZ / SLEEP_CLK_MHZ_X1K) * 4;
  localparam int SLEEP_CNT_W       = 14;

  // Audio signals of the radio core, grouped.
  typedef struct packed {
    logic bitClk;
    logic frameSync;
    logic dataOut;
  } bpr_audio_out_s;

  // Serial data and flow-control signals of the radio core.
  typedef struct packed {
    logic txData;
    logic rxReady;
  } bpr_uart_out_s;

  // Wake and general-purpose signals of the radio core toward the host-wake pin.
  typedef struct packed {
    logic value;
    logic enable;
  } bpr_gpio_s;

endpackage : bpr_pkg

// >>> bpr_pin_routing.sv
`timescale 1ns/1ns
// Summary of operation
// - After reset, wake pins are wake/GPIO and host serial pins are plain UART.
// - Audio routing puts clock on RTS, data out on CTS, sync on host-wake, data-in on dev-wake.
// - While audio is routed, sleep signalling travels in-band over receive and transmit only.
// - Clear-to-send input is active low; low allows the core to transmit.
// - Request-to-send output is active low; low says the core can accept data.
// - Serial data comes in on the receive pin and leaves on the transmit pin.
// - Audio clock and frame sync each work as master (driven) or slave (sampled).
// - Clock request is asserted when either the LAN or the radio section needs it.
// - An external 32.768 kHz sleep clock is accepted on the sleep clock input.
// - With no sleep clock present, low-energy logic stays powered and deep sleep is refused.
// - While the radio power enable is low, this routing is held in reset.

// Shared pin map in the two routings.
// Pin                 | default routing            | audio routing
// request-to-send     | ready to accept, low true  | audio bit clock, driven as master only
// clear-to-send       | permit to transmit, input  | audio data output, always driven
// host-wake           | wake or general purpose    | frame sync, driven as master only
// device-wake         | wake input                 | audio data input
// Receive and transmit keep their serial function in both routings, so the host link never
// drops. With audio routed there is no hardware flow control, and the core must move its
// sleep handshake into the serial transport itself.
//
// Timing seen from outside: a settings change reaches the pins two clock edges later, one
// edge for the settings register and one for the pin register. A pin level reaches the core
// two edges later, through the synchronisers. Slave audio clock and sync are sampled by the
// system clock, so they must be far slower than it; a fast external bit clock is not served.
module bpr_pin_routing (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    radio_power_enable,
  // Software settings of the radio core.
  input  wire logic                    routeSelect,
  input  wire logic                    clkMasterSel,
  input  wire logic                    syncMasterSel,
  // Radio core UART side.
  input  wire bpr_pkg::bpr_uart_out_s  coreUart,
  output logic                         coreRxData,
  output logic                         coreTxAllowed,
  output logic                         inbandSleepMode,
  // Radio core wake and general-purpose side.
  input  wire bpr_pkg::bpr_gpio_s      coreHostWake,
  output logic                         coreDevWake,
  // Radio core audio side.
  input  wire bpr_pkg::bpr_audio_out_s coreAudio,
  output logic                         coreAudioIn,
  output logic                         coreAudioBitClk,
  output logic                         coreAudioFrameSync,
  // Clock request sources and pin.
  input  wire logic                    lanClockNeed,
  input  wire logic                    radioClockNeed,
  output logic                         clockRequestOut,
  // Sleep clock.
  input  wire logic                    sleep_clock_in,
  output logic                         sleepClockPresent,
  output logic                         deepSleepAllowed,
  // Host serial pins.
  input  wire logic                    host_serial_rx,
  output logic                         host_serial_tx,
  // Request-to-send pin, two-way so it can carry the audio clock in slave mode.
  input  wire logic                    host_request_send_in,
  output logic                         host_request_send_out_low,
  output logic                         host_request_send_oe,
  // Clear-to-send pin, turned into an output for audio data.
  input  wire logic                    host_clear_send_in_low,
  output logic                         host_clear_send_out,
  output logic                         host_clear_send_oe,
  // Host-wake pin.
  input  wire logic                    host_wake_in,
  output logic                         host_wake_out,
  output logic                         host_wake_oe,
  // Device-wake pin.
  input  wire logic                    radio_wake_in,
  output logic                         radio_wake_out,
  output logic                         radio_wake_oe
);

  // Routing decode used by every steering point; one definition keeps them in step.
  function automatic logic route_is_audio(input logic routeBit);
    route_is_audio = (routeBit == bpr_pkg::ROUTE_AUDIO);
  endfunction : route_is_audio

  // The watchdog limit must fit its counter, or the cast would truncate it and raise the absent-clock flag too early.
  if (bpr_pkg::SLEEP_TIMEOUT_CYC >= (1 << bpr_pkg::SLEEP_CNT_W)) begin : g_bad_timeout
    $error("sleep timeout does not fit its counter");
  end

  // A limit shorter than one sleep period would flag a healthy clock as absent.
  if (bpr_pkg::SLEEP_TIMEOUT_CYC < (bpr_pkg::SYS_CLK_HZ / bpr_pkg::SLEEP_CLK_MHZ_X1K)) begin : g_short_timeout
    $error("sleep timeout shorter than one sleep period");
  end

  // Pin inputs pass two flip-flops; bit order {rx, rts, cts, hostWake, devWake, sleepClk, powerEn}.
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] syncA_r, syncA_nxt;
  logic [NSYNC-1:0] syncB_r, syncB_nxt;
  logic             rxS, rtsInS, ctsS, hostWakeS, devWakeS, sleepS, powerS;

  always_comb begin
    syncA_nxt = {host_serial_rx, host_request_send_in, host_clear_send_in_low,
                 host_wake_in, radio_wake_in, sleep_clock_in, radio_power_enable};
    syncB_nxt = syncA_r;
  end

  // The synchronisers run under the plain reset so the power enable itself can be seen.
  // Were they held by the power reset too, a low enable could never be released again.
  // Only the second stage is read anywhere; the first may go metastable on a pin edge.
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncA_r <= 7'h00;
      syncB_r <= 7'h00;
    end else begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
    end
  end

  assign {rxS, rtsInS, ctsS, hostWakeS, devWakeS, sleepS, powerS} = syncB_r;

  // Routing state is held in reset whenever the radio section is unpowered.
  // The enable is seen two edges late, so the pins stay live that long after it falls.
  logic blockReset;
  assign blockReset = reset | ~powerS;

  // Registered settings; data outputs to pins come from these and the pin flops below.
  // All three are taken on the same edge, so a combined change switches the pins at once.
  logic audioRoute_r, audioRoute_nxt;
  logic clkMaster_r, clkMaster_nxt;
  logic syncMaster_r, syncMaster_nxt;

  always_comb begin
    audioRoute_nxt = routeSelect;
    clkMaster_nxt  = clkMasterSel;
    syncMaster_nxt = syncMasterSel;
  end

  always_ff @(posedge mclk) begin
    if (blockReset) begin
      audioRoute_r <= bpr_pkg::RST_ROUTE_SEL;
      clkMaster_r  <= bpr_pkg::RST_CLK_MASTER;
      syncMaster_r <= bpr_pkg::RST_SYN_MASTER;
    end else begin
      audioRoute_r <= audioRoute_nxt;
      clkMaster_r  <= clkMaster_nxt;
      syncMaster_r <= syncMaster_nxt;
    end
  end

  // Pin output values and enables, registered so the pins never glitch on a mux change.
  logic txPin_r, txPin_nxt;
  logic rtsPin_r, rtsPin_nxt, rtsOe_r, rtsOe_nxt;
  logic ctsPin_r, ctsPin_nxt, ctsOe_r, ctsOe_nxt;
  logic hwPin_r, hwPin_nxt, hwOe_r, hwOe_nxt;
  logic dwPin_r, dwPin_nxt, dwOe_r, dwOe_nxt;
  logic clkReq_r, clkReq_nxt;

  always_comb begin
    txPin_nxt  = coreUart.txData;
    clkReq_nxt = lanClockNeed | radioClockNeed;
    if (route_is_audio(audioRoute_r)) begin
      // Audio clock on request-to-send, driven only as master.
      rtsPin_nxt = coreAudio.bitClk;
      rtsOe_nxt  = clkMaster_r;
      // Clear-to-send becomes the audio data output.
      ctsPin_nxt = coreAudio.dataOut;
      ctsOe_nxt  = 1'b1;
      // Frame sync on host-wake, driven only as master.
      hwPin_nxt  = coreAudio.frameSync;
      hwOe_nxt   = syncMaster_r;
      // Device-wake is audio input only.
      dwPin_nxt  = 1'b0;
      dwOe_nxt   = 1'b0;
    end else begin
      // Ready to accept is shown by a low level.
      rtsPin_nxt = ~coreUart.rxReady;
      rtsOe_nxt  = 1'b1;
      ctsPin_nxt = 1'b0;
      ctsOe_nxt  = 1'b0;
      hwPin_nxt  = coreHostWake.value;
      hwOe_nxt   = coreHostWake.enable;
      dwPin_nxt  = 1'b0;
      dwOe_nxt   = 1'b0;
    end
  end

  // In reset the request-to-send pin is driven high: not ready, which stops the host safely.
  // The transmit pin idles high, the serial line's idle level, so no false start bit is sent.
  // The other audio-capable pins are released, so an external master never fights the device on them.
  always_ff @(posedge mclk) begin
    if (blockReset) begin
      txPin_r  <= 1'b1;
      rtsPin_r <= 1'b1;
      rtsOe_r  <= 1'b1;
      ctsPin_r <= 1'b0;
      ctsOe_r  <= 1'b0;
      hwPin_r  <= 1'b0;
      hwOe_r   <= 1'b0;
      dwPin_r  <= 1'b0;
      dwOe_r   <= 1'b0;
    end else begin
      txPin_r  <= txPin_nxt;
      rtsPin_r <= rtsPin_nxt;
      rtsOe_r  <= rtsOe_nxt;
      ctsPin_r <= ctsPin_nxt;
      ctsOe_r  <= ctsOe_nxt;
      hwPin_r  <= hwPin_nxt;
      hwOe_r   <= hwOe_nxt;
      dwPin_r  <= dwPin_nxt;
      dwOe_r   <= dwOe_nxt;
    end
  end

  // The clock request is shared with the LAN section, so it ignores the radio power reset.
  // A LAN need must still reach the host while the radio section is unpowered.
  always_ff @(posedge mclk) begin
    if (reset) begin
      clkReq_r <= 1'b0;
    end else begin
      clkReq_r <= clkReq_nxt;
    end
  end

  // Sleep clock watchdog: any edge restarts the count; a stuck-low input means no clock.
  // The counter stops at its limit rather than wrapping, so the absent flag holds until the next edge.
  // A clock far slower than nominal is reported absent, which keeps deep sleep refused.
  logic                          sleepPrev_r, sleepPrev_nxt;
  logic [bpr_pkg::SLEEP_CNT_W-1:0] sleepCnt_r, sleepCnt_nxt;
  logic                          sleepOk_r, sleepOk_nxt;

  always_comb begin
    sleepPrev_nxt = sleepS;
    sleepCnt_nxt  = sleepCnt_r;
    sleepOk_nxt   = sleepOk_r;
    if (sleepS != sleepPrev_r) begin
      sleepCnt_nxt = '0;
      sleepOk_nxt  = 1'b1;
    end else if (sleepCnt_r == bpr_pkg::SLEEP_CNT_W'(bpr_pkg::SLEEP_TIMEOUT_CYC)) begin
      sleepOk_nxt  = 1'b0;
    end else begin
      sleepCnt_nxt = sleepCnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (blockReset) begin
      sleepPrev_r <= 1'b0;
      sleepCnt_r  <= '0;
      sleepOk_r   <= 1'b0;
    end else begin
      sleepPrev_r <= sleepPrev_nxt;
      sleepCnt_r  <= sleepCnt_nxt;
      sleepOk_r   <= sleepOk_nxt;
    end
  end

  // Outputs toward the radio core; inputs from pins are steered by the routing select.
  // With audio routed the clear-to-send pin is an output, so the core may always transmit.
  // Unused device-wake and audio data inputs read low; slave audio clock and sync follow their pins in either routing.
  always_comb begin
    coreRxData         = rxS;
    coreTxAllowed      = route_is_audio(audioRoute_r) ? 1'b1 : ~ctsS;
    inbandSleepMode    = audioRoute_r;
    coreDevWake        = route_is_audio(audioRoute_r) ? 1'b0 : devWakeS;
    coreAudioIn        = route_is_audio(audioRoute_r) ? devWakeS : 1'b0;
    coreAudioBitClk    = clkMaster_r ? coreAudio.bitClk : rtsInS;
    coreAudioFrameSync = syncMaster_r ? coreAudio.frameSync : hostWakeS;
    sleepClockPresent  = sleepOk_r;
    deepSleepAllowed   = sleepOk_r;
  end

  // Pin drivers straight from flip-flops.
  // No gate stands between a register and a pin, so a routing change cannot glitch a pin.
  assign host_serial_tx            = txPin_r;
  assign host_request_send_out_low = rtsPin_r;
  assign host_request_send_oe      = rtsOe_r;
  assign host_clear_send_out       = ctsPin_r;
  assign host_clear_send_oe        = ctsOe_r;
  assign host_wake_out             = hwPin_r;
  assign host_wake_oe              = hwOe_r;
  assign radio_wake_out            = dwPin_r;
  assign radio_wake_oe             = dwOe_r;
  assign clockRequestOut           = clkReq_r;

endmodule : bpr_pin_routing

// >>> bpr_far_end.sv
`timescale 1ns/1ns
// Audio codec and sleep oscillator beside the routing block.
module bpr_far_end (
  // Clock and scenario controls.
  input  wire logic mclk, codecDrives, sleepOn,
  // Device pin drive.
  input  wire logic rtsOutLow, rtsOe, wakeOut, wakeOe,
  // Resolved pin levels.
  output logic      rtsPin, wakePin, sleepPin
);
  logic [7:0] div_r = 8'h0;
  // Codec timing: bit clock at mclk/16, one sync slot every 128 cycles.
  always @(posedge mclk) div_r <= div_r + 8'h1;
  // A released line floats, so it toggles instead of keeping its last level.
  assign rtsPin = rtsOe ? rtsOutLow : codecDrives ? div_r[3] : div_r[0];
  assign wakePin = wakeOe ? wakeOut : codecDrives ? (div_r[6:4] == 3'h0) : div_r[0];
  // Sleep clock near 32.768 kHz, held low while absent.
  initial sleepPin = 1'b0;
  always #15259 sleepPin = sleepOn ? ~sleepPin : 1'b0;
endmodule : bpr_far_end

// >>> bpr_pin_routing_sva.sv
`timescale 1ns/1ns
// Port checks; live waits out the reset and power-enable synchronisers.
module bpr_pin_routing_chk (
  // Clock, reset and settings.
  input wire logic mclk, reset, radio_power_enable, routeSelect, clkMasterSel, syncMasterSel,
  // Core side.
  input wire bpr_pkg::bpr_uart_out_s  coreUart,
  input wire bpr_pkg::bpr_audio_out_s coreAudio,
  input wire bpr_pkg::bpr_gpio_s      coreHostWake,
  input wire logic lanClockNeed, radioClockNeed, clockRequestOut, inbandSleepMode,
  // Pins.
  input wire logic host_serial_tx, host_request_send_out_low, host_request_send_oe,
  input wire logic host_clear_send_out, host_clear_send_oe, host_wake_out, host_wake_oe
);
  logic [2:0] onCnt_r, onCnt_nxt, offCnt_r, offCnt_nxt;
  logic       live, off;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Saturating settle counters, so long runs never wrap.
  always_comb begin
    onCnt_nxt = (reset || !radio_power_enable) ? 3'h0 : onCnt_r + {2'h0, onCnt_r != 3'h7};
    offCnt_nxt = radio_power_enable ? 3'h0 : offCnt_r + {2'h0, offCnt_r != 3'h7};
  end
  always_ff @(posedge mclk) begin
    onCnt_r <= onCnt_nxt;
    offCnt_r <= offCnt_nxt;
  end
  assign live = onCnt_r > 3'h5;
  assign off = offCnt_r > 3'h4;
  property p_tx; live |-> host_serial_tx == $past(coreUart.txData); endproperty
  a_tx: assert property (p_tx) else $error("tx pin lost core data");
  property p_rts; live && !$past(routeSelect, 2)
    |-> host_request_send_oe && host_request_send_out_low == !$past(coreUart.rxReady); endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_cts; live && $past(routeSelect, 2)
    |-> host_clear_send_oe && host_clear_send_out == $past(coreAudio.dataOut); endproperty
  a_cts: assert property (p_cts) else $error("audio out missing on cts pin");
  property p_dir; live && $past(routeSelect, 2) |-> host_request_send_oe == $past(clkMasterSel, 2)
    && host_wake_oe == $past(syncMasterSel, 2); endproperty
  a_dir: assert property (p_dir) else $error("audio clock or sync direction wrong");
  property p_wake; live && !$past(routeSelect, 2) |-> !host_clear_send_oe
    && host_wake_oe == $past(coreHostWake.enable) && host_wake_out == $past(coreHostWake.value); endproperty
  a_wake: assert property (p_wake) else $error("default wake routing wrong");
  property p_req; !$past(reset) |-> clockRequestOut == ($past(lanClockNeed) || $past(radioClockNeed)); endproperty
  a_req: assert property (p_req) else $error("clock request wrong");
  property p_band; live |-> inbandSleepMode == $past(routeSelect); endproperty
  a_band: assert property (p_band) else $error("in-band sleep mode wrong");
  property p_held; off |-> host_serial_tx && host_request_send_out_low && !host_clear_send_oe && !host_wake_oe; endproperty
  a_held: assert property (p_held) else $error("pins active while powered down");
  c_audio: cover property (live && inbandSleepMode);
  c_slave: cover property (live && $past(routeSelect, 2) && !host_request_send_oe);
  c_req: cover property (clockRequestOut);
endmodule : bpr_pin_routing_chk
bind bpr_pin_routing bpr_pin_routing_chk chk_i (.mclk, .reset, .radio_power_enable, .routeSelect, .clkMasterSel,
  .syncMasterSel, .coreUart, .coreAudio, .coreHostWake, .lanClockNeed, .radioClockNeed, .clockRequestOut,
  .inbandSleepMode, .host_serial_tx, .host_request_send_out_low, .host_request_send_oe, .host_clear_send_out,
  .host_clear_send_oe, .host_wake_out, .host_wake_oe);

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0, reset = 1'b1, radio_power_enable = 1'b1, routeSelect = 1'b0, clkMasterSel = 1'b0;
  logic syncMasterSel = 1'b0, lanClockNeed = 1'b0, radioClockNeed = 1'b0, host_serial_rx = 1'b1;
  logic host_clear_send_in_low = 1'b1, radio_wake_in = 1'b0, codecDrives = 1'b0, sleepOn = 1'b0;
  bpr_pkg::bpr_uart_out_s  coreUart = 2'h0;
  bpr_pkg::bpr_gpio_s      coreHostWake = 2'h0;
  bpr_pkg::bpr_audio_out_s coreAudio = 3'h0;
  logic coreRxData, coreTxAllowed, inbandSleepMode, coreDevWake, coreAudioIn, coreAudioBitClk, coreAudioFrameSync;
  logic clockRequestOut, sleep_clock_in, sleepClockPresent, deepSleepAllowed, host_serial_tx, host_request_send_in;
  logic host_request_send_out_low, host_request_send_oe, host_clear_send_out, host_clear_send_oe, host_wake_in;
  logic host_wake_out, host_wake_oe, radio_wake_out, radio_wake_oe;
  int   fails = 0, samples_checked = 0, cycles = 0;
  always #5 mclk = ~mclk;
  bpr_pin_routing bpr_pin_routing_i (.mclk, .reset, .radio_power_enable, .routeSelect, .clkMasterSel,
    .syncMasterSel, .coreUart, .coreRxData, .coreTxAllowed, .inbandSleepMode, .coreHostWake, .coreDevWake,
    .coreAudio, .coreAudioIn, .coreAudioBitClk, .coreAudioFrameSync, .lanClockNeed, .radioClockNeed,
    .clockRequestOut, .sleep_clock_in, .sleepClockPresent, .deepSleepAllowed, .host_serial_rx, .host_serial_tx,
    .host_request_send_in, .host_request_send_out_low, .host_request_send_oe, .host_clear_send_in_low,
    .host_clear_send_out, .host_clear_send_oe, .host_wake_in, .host_wake_out, .host_wake_oe, .radio_wake_in,
    .radio_wake_out, .radio_wake_oe);
  bpr_far_end bpr_far_end_i (.mclk, .codecDrives, .sleepOn, .rtsOutLow(host_request_send_out_low),
    .rtsOe(host_request_send_oe), .wakeOut(host_wake_out), .wakeOe(host_wake_oe), .rtsPin(host_request_send_in),
    .wakePin(host_wake_in), .sleepPin(sleep_clock_in));
  task automatic check(input string what, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // Checks land 1 ns after an edge so the edge's own updates have settled.
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic give_verdict();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Hang guard, sized well past the sleep-clock scenario.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  // Default routing: both levels of every flow-control and wake signal, with the host-wake enable held on.
  task automatic t_uart();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      host_clear_send_in_low <= i[0];
      host_serial_rx <= i[0];
      radio_wake_in <= i[0];
      coreUart <= {i[0], i[0]};
      coreHostWake <= {i[0], 1'b1};
      step(5);
      check("tx allowed", coreTxAllowed, ~i[0]);
      check("rx data", coreRxData, i[0]);
      check("tx pin", host_serial_tx, i[0]);
      check("rts pin", host_request_send_out_low, ~i[0]);
      check("wake out", host_wake_out, i[0]);
      check("dev wake", coreDevWake, i[0]);
      check("cts oe", host_clear_send_oe, 1'b0);
    end
  endtask : t_uart
  // Audio routing as master with two patterns, then as slave to the codec.
  task automatic t_audio();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      {routeSelect, clkMasterSel, syncMasterSel} <= 3'h7;
      coreAudio <= {i[0], ~i[0], i[0]};
      radio_wake_in <= 1'b1;
      step(5);
      check("in-band", inbandSleepMode, 1'b1);
      check("cts out", host_clear_send_out, i[0]);
      check("rts out", host_request_send_out_low, i[0]);
      check("sync out", host_wake_out, ~i[0]);
      check("audio in", coreAudioIn, 1'b1);
      check("master clock", coreAudioBitClk, i[0]);
      check("dev wake oe", radio_wake_oe, 1'b0);
      check("tx allowed", coreTxAllowed, 1'b1);
    end
    @(posedge mclk);
    {clkMasterSel, syncMasterSel, codecDrives} <= 3'h1;
    step(4);
    @(host_request_send_in);
    step(4);
    check("slave clock", coreAudioBitClk, host_request_send_in);
    step(4);
    @(posedge host_wake_in);
    step(4);
    check("slave sync", coreAudioFrameSync, 1'b1);
  endtask : t_audio
  // Clock request for every need pair, with power enable dropped on odd steps.
  task automatic t_power();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      coreUart <= 2'h0;
      {lanClockNeed, radioClockNeed} <= i[1:0];
      radio_power_enable <= ~i[0];
      step(8);
      check("clk req", clockRequestOut, |i[1:0]);
      check("cts oe", host_clear_send_oe, ~i[0]);
      check("tx", host_serial_tx, i[0]);
    end
    @(posedge mclk);
    radio_power_enable <= 1'b1;
    routeSelect <= 1'b0;
    step(8);
    check("rts oe", host_request_send_oe, 1'b1);
  endtask : t_power
  task automatic t_sleep();
    @(posedge mclk);
    sleepOn <= 1'b1;
    step(7000);
    check("sleep present", sleepClockPresent, 1'b1);
    check("deep sleep on", deepSleepAllowed, 1'b1);
    @(posedge mclk);
    sleepOn <= 1'b0;
    step(14000);
    check("deep sleep", deepSleepAllowed, 1'b0);
    check("sleep absent", sleepClockPresent, 1'b0);
  endtask : t_sleep
  initial begin
    step(8);
    check("tx reset", host_serial_tx, 1'b1);
    check("cts oe reset", host_clear_send_oe, 1'b0);
    @(posedge mclk);
    reset <= 1'b0;
    step(8);
    t_uart();
    t_audio();
    t_power();
    t_sleep();
    give_verdict();
  end
endmodule : tb_top
